// ==== hdl/wblk_pkg.sv ====
// holds the shared constants and types of the write-block sequencer pair
// assumes one 100 MHz clock and a synchronous active-low reset everywhere
package wblk_pkg;
  // processor cycle request codes
  localparam logic [2:0] REQ_IDLE        = 3'h0;  // no request
  localparam logic [2:0] REQ_WRITE_BLOCK = 3'h3;  // write block request
  // processor cycle acknowledge codes
  localparam logic [2:0] ACK_NONE        = 3'h0;  // no acknowledge
  localparam logic [2:0] ACK_OK          = 3'h1;  // cycle acknowledged
  // bridge command codes
  localparam logic [2:0] BCMD_NONE       = 3'h0;  // no command
  localparam logic [2:0] BCMD_CACK_REQ   = 3'h1;  // ask for a cycle ack
  // address field and decode
  localparam int ADDR_HI     = 33;                 // top decoded address bit
  localparam int ADDR_LO     = 5;                  // lowest decoded bit
  localparam int ADDR_W      = ADDR_HI + 1;        // address width
  localparam int SPACE_MSB   = 33;                 // space select bits
  localparam int SPACE_LSB   = 32;
  localparam logic [1:0] SPACE_CACHEABLE = 2'h0;   // cacheable memory
  localparam logic [1:0] SPACE_NONCACHE  = 2'h1;   // noncacheable memory
  localparam logic [1:0] SPACE_IO        = 2'h2;   // remote i/o space
  // data widths
  localparam int OCTA_W      = 128;                // one octaword
  localparam int LINE_PTR_W  = 2;                  // bridge line pointer
  localparam int FIFO_DEPTH  = 32;                 // side-bus buffer depth
  // tag status driven for a fill line
  localparam logic [1:0] TAG_VALID_DIRTY = 2'h3;   // valid and dirty
  // sequencer cycle numbers
  localparam logic [3:0] CYC_ACK_VICTIM  = 4'hA;   // ack with victim
  localparam logic [3:0] CYC_ACK_NOVIC   = 4'h7;   // ack without victim
  localparam logic [3:0] CYC_ACK_NOALLOC = 4'h3;   // ack no allocate
  localparam logic [3:0] CYC_IO_FLOAT    = 4'h4;   // i/o float guard cycle
  // flow selection
  typedef enum logic [2:0] {
    FLOW_VICTIM, FLOW_NOVICTIM, FLOW_NOALLOC, FLOW_IO
  } flow_t;
endpackage

// ==== hdl/wblk_if.sv ====
// holds the link between the processor end and the sequencer end
// assumes both ends share one clock; the testbench instantiates it
`timescale 1ns/10ps
interface wblk_if;
  logic [2:0]               proc_cycle_request;       // processor request
  logic [wblk_pkg::ADDR_W-1:0] system_address;        // system address
  logic [wblk_pkg::OCTA_W-1:0] proc_data_bus;         // processor write data
  logic                     proc_data_bus_oe_n;       // low while cpu drives
  logic                     proc_full_line;           // whole line written
  logic                     early_output_enable;      // early oe enable
  logic                     cache_tag_output_enable;  // tag sram oe
  logic                     proc_data_output_enable;  // cpu data oe
  logic                     data_output_hold;         // hold cpu data oe
  logic                     tag_output_enable_request;// keep tags driven
  logic                     second_octaword_select;   // ask second octaword
  logic                     cache_data_output_enable_request; // data oe
  logic                     cache_line_address;       // cache address bit 4
  logic                     cache_data_write_request; // data write enable
  logic                     tag_write_request;        // tag write enable
  logic                     cache_data_write_strobe;  // data sram we
  logic                     cache_tag_write_strobe;   // tag sram we
  logic [1:0]               tag_status;               // tag status driven
  logic                     proc_dcache_invalidate;   // dcache invalidate
  logic [2:0]               proc_cycle_acknowledge;   // cycle acknowledge
  // device end
  modport dev (
    input  proc_cycle_request, system_address, proc_data_bus,
           proc_data_bus_oe_n, proc_full_line,
    output early_output_enable, cache_tag_output_enable,
           proc_data_output_enable, data_output_hold,
           tag_output_enable_request, second_octaword_select,
           cache_data_output_enable_request, cache_line_address,
           cache_data_write_request, tag_write_request,
           cache_data_write_strobe, cache_tag_write_strobe, tag_status,
           proc_dcache_invalidate, proc_cycle_acknowledge
  );
  // processor end
  modport proc (
    output proc_cycle_request, system_address, proc_data_bus,
           proc_data_bus_oe_n, proc_full_line,
    input  early_output_enable, cache_tag_output_enable,
           proc_data_output_enable, data_output_hold,
           tag_output_enable_request, second_octaword_select,
           cache_data_output_enable_request, cache_line_address,
           cache_data_write_request, tag_write_request,
           cache_data_write_strobe, cache_tag_write_strobe, tag_status,
           proc_dcache_invalidate, proc_cycle_acknowledge
  );
endinterface

// ==== hdl/wblk_fifo.sv ====
// holds a synchronous valid/ready fifo for buffered i/o write octawords
// assumes a single clock and synchronous active-low reset
`timescale 1ns/10ps
module wblk_fifo #(
  parameter int WIDTH = 128,  // word width
  parameter int DEPTH = 32    // word count, power of two
) (
  input  wire logic             clk_i,      // clock
  input  wire logic             rst_n_i,    // sync reset, active low
  input  wire logic             in_valid_i, // write side valid
  output logic                  in_ready_o, // write side ready
  input  wire logic [WIDTH-1:0] in_data_i,  // write data
  output logic                  out_valid_o,// read side valid
  input  wire logic             out_ready_i,// read side ready
  output logic [WIDTH-1:0]      out_data_o  // read data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];   // storage
  logic [AW:0]      wr_ptr_reg;        // write pointer with wrap bit
  logic [AW:0]      rd_ptr_reg;        // read pointer with wrap bit
  logic             full;              // no room
  logic             empty;             // nothing stored
  wire  logic       push = in_valid_i && !full;
  wire  logic       pop  = out_ready_i && !empty;
  assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty       = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end
  // pointer update
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // wblk_fifo

// ==== hdl/wblk_proc_end.sv ====
// holds the processor end: issues write blocks and serves the octawords
// assumes the device end keeps cycle timing; one clock, sync reset
`timescale 1ns/10ps
module wblk_proc_end (
  input  wire logic                          SYS_CLK_I,   // clock
  input  wire logic                          RESETN_I,    // sync reset
  wblk_if.proc                               link,        // to device
  input  wire logic                          START_I,     // start pulse
  input  wire logic [wblk_pkg::ADDR_W-1:0]   ADDR_I,      // address
  input  wire logic [wblk_pkg::OCTA_W-1:0]   DATA0_I,     // octaword 0
  input  wire logic [wblk_pkg::OCTA_W-1:0]   DATA1_I,     // octaword 1
  input  wire logic                          FULL_LINE_I, // full line
  output logic                               BUSY_O,      // in transaction
  output logic                               DONE_O       // ack seen pulse
);
  typedef enum logic [1:0] {P_IDLE, P_REQ, P_DATA, P_WAIT} pstate_t;
  pstate_t                     state_reg;   // processor state
  logic [wblk_pkg::OCTA_W-1:0] data_reg;    // driven octaword
  logic [wblk_pkg::ADDR_W-1:0] addr_reg;    // held address
  logic                        full_reg;    // full line flag
  logic                        drive_reg;   // driving data bus
  logic                        done_reg;    // ack pulse
  wire  logic ack_seen = link.proc_cycle_acknowledge != wblk_pkg::ACK_NONE;
  assign link.proc_cycle_request = (state_reg == P_REQ) ?
                                   wblk_pkg::REQ_WRITE_BLOCK :
                                   wblk_pkg::REQ_IDLE; // R01
  assign link.system_address     = addr_reg;
  assign link.proc_data_bus      = data_reg;
  assign link.proc_data_bus_oe_n = !drive_reg;
  assign link.proc_full_line     = full_reg;
  assign BUSY_O = state_reg != P_IDLE;
  assign DONE_O = done_reg;
  // request, drive octawords, tristate right after the second one, then wait for ack
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      state_reg <= P_IDLE;
      data_reg  <= '0;
      addr_reg  <= '0;
      full_reg  <= 1'b0;
      drive_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        P_IDLE: begin
          if (START_I) begin
            state_reg <= P_REQ;
            addr_reg  <= ADDR_I;
            full_reg  <= FULL_LINE_I;
          end
        end
        P_REQ: begin
          // first octaword once data oe is seen
          if (link.proc_data_output_enable) begin
            data_reg  <= DATA0_I;
            drive_reg <= 1'b1;
            state_reg <= P_DATA;
          end
        end
        P_DATA: begin
          if (link.second_octaword_select) begin
            data_reg  <= DATA1_I; // R04
            state_reg <= P_WAIT;
          end
        end
        P_WAIT: begin
          drive_reg <= 1'b0;      // R06
          if (ack_seen) begin
            state_reg <= P_IDLE;
            done_reg  <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // wblk_proc_end

// ==== hdl/wblk_seq.sv ====
// holds the device end: the cycle sequencer for processor write blocks
// assumes the processor end on the link and the bridge on plain ports;
// the phase edge inputs come from the local clock generator in-domain
//
// Behaviour
// R01: write block starts idle; tag and data oe (tag oe decodes cycle 1, which run never reaches)
// R02: cycle 2 decodes address into space class
// R03: cycle 2: hold, tag request, second select
// R04: cycle 3 drops hold, select, early enable
// R05: dirty victim is read before the fill
// R06: victim cycle 4 data oe on phase1 fall
// R07: cycle 5 address bit 4; cycle 6 oe off
// R08: fill tags valid dirty with write enables
// R09: full line reused, else memory merge
// R10: invalidate dcache: victim always, no victim if valid
// R11: victim address bit 4 phase2 rise, clear cycle 9
// R12: victim flow ack cycle 10, ready cycle 11
// R13: no victim: tag drop 3, tags 4, write 5-6
// R14: no victim ack cycle 7, done cycle 8
// R15: no allocate: disable cache, ack cycle 3
// R16: noncacheable equals no allocate sequence
// R17: bridge drives line pointer during ownership
// R18: i/o octawords load into pointed line
// R19: bridge ack request, ack next cycle
// R20: no bridge ack by 4: data oe guard
// R21: bridge unloads buffered data after ack
// R22: idle keeps early enable and cpu data oe active
`timescale 1ns/10ps
module wblk_seq #(
  parameter int OCTA_W = wblk_pkg::OCTA_W,   // octaword width
  parameter int DEPTH  = wblk_pkg::FIFO_DEPTH // i/o buffer depth
) (
  input  wire logic                        SYS_CLK_I,     // clock
  input  wire logic                        RESETN_I,      // sync reset
  wblk_if.dev                              link,          // to processor
  input  wire logic                        PHASE1_FALL_I, // phase1 falling
  input  wire logic                        PHASE2_FALL_I, // phase2 falling
  input  wire logic                        PHASE2_RISE_I, // phase2 rising
  input  wire logic                        ALLOCATE_EN_I, // write allocate
  input  wire logic                        TAG_HIT_VALID_I, // old line valid
  input  wire logic                        TAG_DIRTY_I,   // victim dirty
  output logic                             MEM_READ_O,    // merge read
  input  wire logic                        MEM_DONE_I,    // merge ready
  input  wire logic [OCTA_W-1:0]           MEM_DATA0_I,   // memory octa 0
  input  wire logic [OCTA_W-1:0]           MEM_DATA1_I,   // memory octa 1
  output logic [OCTA_W-1:0]                FILL_DATA_O,   // to cache
  input  wire logic [2:0]                  BRIDGE_CMD_I,  // bridge command
  input  wire logic [wblk_pkg::LINE_PTR_W-1:0] LINE_PTR_I, // line pointer
  output logic                             SIDE_VALID_O,  // side bus valid
  input  wire logic                        SIDE_READY_I,  // bridge unload
  output logic [OCTA_W-1:0]                SIDE_DATA_O,   // side bus data
  output logic [wblk_pkg::LINE_PTR_W-1:0]  SIDE_LINE_O,   // target line
  output logic                             BUF_STALL_O    // buffer full
);
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_DONE} state_t;
  state_t                state_reg;     // sequencer state
  logic [3:0]            cyc_reg;       // cycle count from the request
  wblk_pkg::flow_t       flow_reg;      // flow chosen in cycle 2
  logic [OCTA_W-1:0]     octa0_reg;     // first written octaword
  logic [OCTA_W-1:0]     octa1_reg;     // second written octaword
  logic                  full_reg;      // full line written
  logic                  valid_reg;     // old line was valid
  logic                  bcack_reg;     // bridge asked for ack
  logic                  a4_reg;        // cache address bit 4
  logic                  doe_reg;       // cache data oe request
  logic [OCTA_W-1:0]     fill_reg;      // fill data out
  logic                  mem_rd_reg;    // memory merge read
  logic [wblk_pkg::LINE_PTR_W-1:0] line_reg; // captured line pointer
  logic                  fifo_in_ready; // buffer has room
  logic                  fifo_valid;    // buffer holds a word
  // space decode of the upper address bits
  wire logic [1:0] space = link.system_address[wblk_pkg::SPACE_MSB:
                                               wblk_pkg::SPACE_LSB];
  wire logic run    = state_reg == S_RUN;
  wire logic is_req = link.proc_cycle_request == wblk_pkg::REQ_WRITE_BLOCK;
  wire logic c2     = run && cyc_reg == 4'h2;
  wire logic c3     = run && cyc_reg == 4'h3;
  wire logic victim = flow_reg == wblk_pkg::FLOW_VICTIM;
  wire logic novic  = flow_reg == wblk_pkg::FLOW_NOVICTIM;
  wire logic noalo  = flow_reg == wblk_pkg::FLOW_NOALLOC;
  wire logic io     = flow_reg == wblk_pkg::FLOW_IO;
  wire logic bcmd_ack = BRIDGE_CMD_I == wblk_pkg::BCMD_CACK_REQ;
  // flow choice from space, allocate and tag status
  wire wblk_pkg::flow_t flow_sel =
    (space == wblk_pkg::SPACE_IO)     ? wblk_pkg::FLOW_IO :
    (space != wblk_pkg::SPACE_CACHEABLE || !ALLOCATE_EN_I) ?
                                         wblk_pkg::FLOW_NOALLOC : // R16
    TAG_DIRTY_I ? wblk_pkg::FLOW_VICTIM : wblk_pkg::FLOW_NOVICTIM; // R05
  // merge step: full line reused, else memory stalls until done
  wire logic mem_wait = (victim && cyc_reg == 4'h8 ||
                         novic && cyc_reg == 4'h5) &&
                        run && !full_reg && !MEM_DONE_I; // R09
  wire logic ack_cycle = run && (
    victim && cyc_reg == wblk_pkg::CYC_ACK_VICTIM ||
    novic  && cyc_reg == wblk_pkg::CYC_ACK_NOVIC  ||
    noalo  && cyc_reg == wblk_pkg::CYC_ACK_NOALLOC ||
    io     && bcack_reg && cyc_reg >= wblk_pkg::CYC_ACK_NOALLOC + 4'h1);
  // i/o octawords wait in the buffer; only i/o stalls on a full buffer
  wire logic io_c2   = c2 && space == wblk_pkg::SPACE_IO;
  wire logic io_push = io_c2 || c3 && io;
  // output decode
  assign link.early_output_enable = !run || cyc_reg < 4'h3;     // R22
  assign link.cache_tag_output_enable = run && cyc_reg == 4'h1; // R01
  assign link.proc_data_output_enable = !run || cyc_reg < 4'h4 ||
         (novic && cyc_reg >= wblk_pkg::CYC_ACK_NOVIC);         // R14
  assign link.data_output_hold       = c2;                      // R03
  assign link.second_octaword_select = c2 && (fifo_in_ready || !io_c2); // R03
  assign link.tag_output_enable_request = run && cyc_reg >= 4'h2 && (
         victim ? cyc_reg < 4'h6 :                              // R07
         io     ? !(cyc_reg > 4'h3 && bcack_reg) :              // R19
                  cyc_reg < 4'h3);                              // R13 R15
  assign link.cache_data_output_enable_request = doe_reg;
  assign link.cache_line_address = a4_reg;
  wire logic wr_now = run && !mem_wait && (
         victim && (cyc_reg == 4'h8 || cyc_reg == 4'h9) ||
         novic  && (cyc_reg == 4'h5 || cyc_reg == 4'h6));       // R13
  wire logic tag_now = run && (victim && cyc_reg == 4'h7 ||
                               novic && cyc_reg == 4'h5);       // R08
  assign link.cache_data_write_request = wr_now || victim && run &&
                                         cyc_reg == 4'h7;       // R08
  assign link.tag_write_request       = tag_now;
  assign link.cache_data_write_strobe = wr_now;
  assign link.cache_tag_write_strobe  = tag_now;
  assign link.tag_status = (run && (victim && cyc_reg >= 4'h7 ||
         novic && cyc_reg >= 4'h4)) ? wblk_pkg::TAG_VALID_DIRTY : 2'h0;
  assign link.proc_dcache_invalidate = wr_now && (
         victim && cyc_reg == 4'h8 ||                           // R10
         novic && cyc_reg == 4'h5 && valid_reg);                // R10
  assign link.proc_cycle_acknowledge = ack_cycle ? wblk_pkg::ACK_OK :
                                       wblk_pkg::ACK_NONE;      // R12 R14
  assign FILL_DATA_O  = fill_reg;
  assign MEM_READ_O   = mem_rd_reg;
  assign SIDE_VALID_O = fifo_valid && state_reg != S_RUN;       // R21
  assign BUF_STALL_O  = !fifo_in_ready;
  // cycle counter and flow state
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      state_reg <= S_IDLE;
      cyc_reg   <= 4'h0;
      flow_reg  <= wblk_pkg::FLOW_NOALLOC;
      full_reg  <= 1'b0;
      valid_reg <= 1'b0;
      bcack_reg <= 1'b0;
      line_reg  <= '0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (is_req) begin                                     // R01
            state_reg <= S_RUN;
            cyc_reg   <= 4'h2;
            bcack_reg <= 1'b0;
            line_reg  <= LINE_PTR_I;                            // R17
          end
        end
        S_RUN: begin
          if (c2) begin
            flow_reg  <= flow_sel;                              // R02
            full_reg  <= link.proc_full_line;
            valid_reg <= TAG_HIT_VALID_I;
          end
          if (io && bcmd_ack) bcack_reg <= 1'b1;                // R19
          if (ack_cycle) begin
            state_reg <= S_DONE;
          end else if (!mem_wait && !(io_c2 && !fifo_in_ready) &&
                       cyc_reg != 4'hF) begin
            cyc_reg <= cyc_reg + 4'h1;
          end
        end
        S_DONE: begin
          state_reg <= S_IDLE;                                  // R12
        end
      endcase
    end
  end
  // cache address bit 4, data oe timing and fill data
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      a4_reg     <= 1'b0;
      doe_reg    <= 1'b0;
      fill_reg   <= '0;
      mem_rd_reg <= 1'b0;
      octa0_reg  <= '0;
      octa1_reg  <= '0;
    end else begin
      if (c2) octa0_reg <= link.proc_data_bus;
      if (c3) octa1_reg <= link.proc_data_bus;
      if (!run) begin
        a4_reg  <= 1'b0;                                        // R22
        doe_reg <= 1'b0;
      end else if (victim) begin
        if (cyc_reg == 4'h4 && PHASE1_FALL_I) doe_reg <= 1'b1;  // R06
        if (cyc_reg == 4'h6) doe_reg <= 1'b0;                   // R07
        if (cyc_reg == 4'h5) a4_reg <= 1'b1;                    // R07
        if (cyc_reg == 4'h6) a4_reg <= 1'b0;
        if (cyc_reg == 4'h8 && PHASE2_RISE_I) a4_reg <= 1'b1;   // R11
        if (cyc_reg == 4'h9 && PHASE2_FALL_I) a4_reg <= 1'b0;   // R11
      end else if (io) begin
        if (cyc_reg >= wblk_pkg::CYC_IO_FLOAT && !bcack_reg)
          doe_reg <= 1'b1;                                      // R20
        if (bcack_reg) doe_reg <= 1'b0;
      end else if (novic) begin
        a4_reg <= cyc_reg == 4'h5 && !mem_wait;
      end
      mem_rd_reg <= mem_wait;                                   // R09
      if (wr_now) begin
        fill_reg <= ((victim && cyc_reg == 4'h8) ||
                     (novic && cyc_reg == 4'h5)) ?
                    (full_reg ? octa0_reg : MEM_DATA0_I | octa0_reg) :
                    (full_reg ? octa1_reg : MEM_DATA1_I | octa1_reg);
      end
    end
  end
  // i/o write buffer toward the bridge side bus
  wblk_fifo #(
    .WIDTH (OCTA_W + 2),
    .DEPTH (DEPTH)
  ) u_iobuf (
    .clk_i       (SYS_CLK_I),
    .rst_n_i     (RESETN_I),
    .in_valid_i  (io_push),                          // R18
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({line_reg, link.proc_data_bus}),   // R18
    .out_valid_o (fifo_valid),
    .out_ready_i (SIDE_READY_I && state_reg != S_RUN),
    .out_data_o  ({SIDE_LINE_O, SIDE_DATA_O})
  );
endmodule // wblk_seq

// ==== verification/wblk_properties.sv ====
// checker of the link between the two ends
// assumes the bench instantiates it beside the interface, one clock
`timescale 1ns/10ps
module wblk_properties (
  input wire logic                        SYS_CLK_I,
  input wire logic                        RESETN_I,
  input wire logic [wblk_pkg::ADDR_W-1:0] system_address,
  input wire logic                        second_octaword_select,
  input wire logic                        data_output_hold,
  input wire logic                        tag_output_enable_request,
  input wire logic                        early_output_enable,
  input wire logic                        cache_data_output_enable_request,
  input wire logic                        cache_data_write_request,
  input wire logic                        tag_write_request,
  input wire logic [1:0]                  tag_status,
  input wire logic                        proc_dcache_invalidate,
  input wire logic [2:0]                  proc_cycle_acknowledge
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire [1:0] spc = system_address[wblk_pkg::SPACE_MSB:wblk_pkg::SPACE_LSB];
  wire       ack = proc_cycle_acknowledge == wblk_pkg::ACK_OK;
  property p_sel; $rose(second_octaword_select) |->
    data_output_hold && tag_output_enable_request; endproperty
  a_sel: assert property (p_sel)
    else $error("select without hold");
  property p_drop; second_octaword_select |=> !second_octaword_select &&
    !data_output_hold && !early_output_enable; endproperty
  a_drop: assert property (p_drop)
    else $error("select or hold stayed up");
  property p_ack; ack |=> proc_cycle_acknowledge == wblk_pkg::ACK_NONE;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack too long");
  property p_quiet; ack |-> !cache_data_write_request &&
    !second_octaword_select; endproperty
  a_quiet: assert property (p_quiet)
    else $error("write at ack");
  property p_inv; proc_dcache_invalidate |-> cache_data_write_request;
  endproperty
  a_inv: assert property (p_inv)
    else $error("stray invalidate");
  property p_tags; tag_write_request |->
    tag_status == wblk_pkg::TAG_VALID_DIRTY; endproperty
  a_tags: assert property (p_tags)
    else $error("bad fill tags");
  property p_nonc; second_octaword_select && spc == wblk_pkg::SPACE_NONCACHE
    |=> ack && !tag_output_enable_request; endproperty
  a_nonc: assert property (p_nonc)
    else $error("late noncache ack");
  property p_vic; $rose(cache_data_output_enable_request) &&
    spc == wblk_pkg::SPACE_CACHEABLE |-> ##[5:40] ack; endproperty
  a_vic: assert property (p_vic)
    else $error("late victim ack");
  c_io: cover property (ack && spc == wblk_pkg::SPACE_IO);
  c_inv: cover property (proc_dcache_invalidate);
  c_nonc: cover property (ack && spc == wblk_pkg::SPACE_NONCACHE);
endmodule // wblk_properties

// ==== verification/test_cpu_write_block_sequencer.sv ====
// bench joining both ends over the link, with a queue model of results
// assumes the design files under hdl/ are compiled first
`timescale 1ns/10ps
module test_cpu_write_block_sequencer;
  logic         clk, rstn, start, full, alloc, hitv, dirty, mdone, hold;
  logic         sready, done, svalid, stall, wr_d;
  logic [33:0]  addr;
  logic [127:0] d0, d1, md0, md1, fill, sdata;
  logic [2:0]   bcmd;
  logic [1:0]   lptr, sline;
  logic [129:0] fq[$], sq[$];  // expected fill and side words
  int           num_errors, check_count, cycles;
  wblk_if wblk_if_i ();
  wblk_proc_end wblk_proc_end_i (.SYS_CLK_I(clk), .RESETN_I(rstn),
    .link(wblk_if_i.proc), .START_I(start), .ADDR_I(addr), .DATA0_I(d0),
    .DATA1_I(d1), .FULL_LINE_I(full), .BUSY_O(), .DONE_O(done));
  wblk_seq wblk_seq_i (.SYS_CLK_I(clk), .RESETN_I(rstn),
    .link(wblk_if_i.dev), .PHASE1_FALL_I(1'b1), .PHASE2_FALL_I(1'b1),
    .PHASE2_RISE_I(1'b1), .ALLOCATE_EN_I(alloc), .TAG_HIT_VALID_I(hitv),
    .TAG_DIRTY_I(dirty), .MEM_READ_O(), .MEM_DONE_I(mdone),
    .MEM_DATA0_I(md0), .MEM_DATA1_I(md1), .FILL_DATA_O(fill),
    .BRIDGE_CMD_I(bcmd), .LINE_PTR_I(lptr), .SIDE_VALID_O(svalid),
    .SIDE_READY_I(sready), .SIDE_DATA_O(sdata), .SIDE_LINE_O(sline),
    .BUF_STALL_O(stall));
  wblk_properties wblk_properties_i (.SYS_CLK_I(clk), .RESETN_I(rstn),
    .system_address(wblk_if_i.system_address),
    .second_octaword_select(wblk_if_i.second_octaword_select),
    .data_output_hold(wblk_if_i.data_output_hold),
    .tag_output_enable_request(wblk_if_i.tag_output_enable_request),
    .early_output_enable(wblk_if_i.early_output_enable),
    .cache_data_output_enable_request(
      wblk_if_i.cache_data_output_enable_request),
    .cache_data_write_request(wblk_if_i.cache_data_write_request),
    .tag_write_request(wblk_if_i.tag_write_request),
    .tag_status(wblk_if_i.tag_status),
    .proc_dcache_invalidate(wblk_if_i.proc_dcache_invalidate),
    .proc_cycle_acknowledge(wblk_if_i.proc_cycle_acknowledge));
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_word(logic [129:0] got, logic [129:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %h exp %h", $time, got, exp);
    end
  endtask
  // one write block; queues the expected words
  task automatic txn(logic [1:0] sp, logic al, logic dy);
    logic [127:0] a, b, m0, m1;
    logic f;
    logic [1:0] l;
    repeat (16) {a, b, m0, m1} = {a[95:0], b, m0, m1, $urandom};
    {f, l} = 3'($urandom);
    addr <= {sp, $urandom}; d0 <= a; d1 <= b; md0 <= m0; md1 <= m1;
    full <= f; alloc <= al; dirty <= dy; lptr <= l; start <= 1'b1;
    hitv <= 1'($urandom);
    @(posedge clk);
    start <= 1'b0;
    if (sp == wblk_pkg::SPACE_IO) begin
      sq.push_back({l, a});
      sq.push_back({l, b});
    end else if (sp == wblk_pkg::SPACE_CACHEABLE && al) begin
      fq.push_back({2'h0, f ? a : a | m0});
      fq.push_back({2'h0, f ? b : b | m1});
    end
    while (done !== 1'b1) @(posedge clk);
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // random far-side behaviour and hang guard; fill shows a cycle late
  always @(posedge clk) begin
    cycles <= cycles + 1;
    mdone <= 1'($urandom);
    sready <= !hold && 1'($urandom);
    bcmd <= $urandom_range(2) == 0 ? wblk_pkg::BCMD_CACK_REQ : 3'h0;
    wr_d <= wblk_if_i.cache_data_write_strobe;
    if (rstn && wr_d) chk_word({2'h0, fill}, fq.pop_front());
    if (rstn && svalid && sready)
      chk_word({sline, sdata}, sq.pop_front());
    if (cycles == 8000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {rstn, start, full, alloc, hitv, dirty, hold} = '0;
    {addr, d0, d1, md0, md1, lptr} = '0;
    num_errors = 0;
    check_count = 0;
    void'($urandom(32'h97355344));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 30; i++)
      txn(2'($urandom_range(2)), 1'($urandom), 1'($urandom));
    while (svalid === 1'b1) @(posedge clk);
    hold <= 1'b1;
    repeat (wblk_pkg::FIFO_DEPTH / 2) txn(wblk_pkg::SPACE_IO, 1'b0, 1'b0);
    chk_flag(stall, 1'b1);
    hold <= 1'b0;
    repeat (200) if (svalid === 1'b1) @(posedge clk);
    chk_flag(svalid, 1'b0);
    stop_test();
  end
endmodule // test_cpu_write_block_sequencer
